// ### rtl/mpio_top.sv
// module: pulse outputs and three counting pulse inputs of a meter
// ****************************************
// Overview of operation
// RQ1: closed output pulse lasts exactly 125 ms
// RQ2: open gap of 125 ms between pulses
// RQ3: energy pulse per lowest energy digit step
// RQ4: volume pulse per second volume digit step
// RQ5: control bit disables both outputs, switches open
// RQ6: per-pulse output values and module type readable
// RQ7: three independent totals readable over bus
// RQ8: selectable weight per input pulse
// RQ9: total preloadable with external meter start value
// RQ10: per-channel unit litres, kWh or none
// RQ11: per-channel serial and manufacturer code stored
// RQ12: external pulses at least 100 ms on/off
// RQ13: short circuit across inputs counts as pulse
// RQ14: synchronise, debounce, one count per cycle
// ****************************************
`timescale 1ns/10ps
module mpio_top #(
    parameter int OUT_CLOSED_CYCLES = mpio_pkg::OUT_CLOSED_CYC,
    parameter int OUT_OPEN_CYCLES = mpio_pkg::OUT_OPEN_CYC,
    parameter int IN_QUAL_CYCLES = mpio_pkg::IN_QUAL_CYC,
    parameter int NUM_IN = 3,
    parameter logic [7:0] MODULE_TYPE = mpio_pkg::MODULE_TYPE_DEFAULT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // increment events from the metrology core
    input wire logic energy_step,
    input wire logic volume_step,
    // switch outputs, high closes the contact
    output logic energy_switch,
    output logic volume_switch,
    // pulse inputs, low while contact closed or wires shorted
    input wire logic [NUM_IN-1:0] pulse_in_n
);
    // ****************************************
    // register file
    // ****************************************
    logic [31:0] ctrl_reg, ctrl_next;
    logic [31:0] cfg_reg [NUM_IN];
    logic [31:0] cfg_next [NUM_IN];
    logic [31:0] serial_reg [NUM_IN];
    logic [31:0] serial_next [NUM_IN];
    logic [31:0] total_reg [NUM_IN];
    logic [31:0] total_next [NUM_IN];
    logic [31:0] rdata_reg, rdata_next;
    logic [NUM_IN-1:0] count_ev;
    logic [1:0] out_busy;

    // weight in tenths of a unit
    function automatic logic [31:0] weight_of(input logic [2:0] sel);
        logic [31:0] w;
        w = 32'h0000_000a;
        case (sel)
            mpio_pkg::WEIGHT_2P5: w = 32'h0000_0019;
            mpio_pkg::WEIGHT_10: w = 32'h0000_0064;
            mpio_pkg::WEIGHT_25: w = 32'h0000_00fa;
            mpio_pkg::WEIGHT_100: w = 32'h0000_03e8;
            mpio_pkg::WEIGHT_250: w = 32'h0000_09c4;
            mpio_pkg::WEIGHT_1000: w = 32'h0000_2710;
            default: w = 32'h0000_000a;
        endcase
        return w;
    endfunction : weight_of

    // writes, preload and accumulation
    always_comb begin
        logic [7:0] base;
        base = 8'h00;
        ctrl_next = ctrl_reg;
        if (reg_wr && reg_addr == mpio_pkg::ADDR_CTRL) begin
            ctrl_next = reg_wdata; // see RQ5
        end
        for (int i = 0; i < NUM_IN; i++) begin
            base = 8'(mpio_pkg::ADDR_CH_BASE + 8'(i) * mpio_pkg::CH_STRIDE);
            cfg_next[i] = cfg_reg[i];
            serial_next[i] = serial_reg[i];
            total_next[i] = total_reg[i];
            if (count_ev[i]) begin
                total_next[i] = total_reg[i] + weight_of(cfg_reg[i][2:0]); // see RQ8
            end
            if (reg_wr && reg_addr == base + {4'h0, mpio_pkg::CH_CFG}) begin
                cfg_next[i] = reg_wdata; // see RQ10
            end else if (reg_wr && reg_addr == base + {4'h0, mpio_pkg::CH_START}) begin
                total_next[i] = reg_wdata; // see RQ9
            end else if (reg_wr && reg_addr == base + {4'h0, mpio_pkg::CH_SERIAL}) begin
                serial_next[i] = reg_wdata; // see RQ11
            end
        end
    end

    // read mux, data one cycle after the strobe
    always_comb begin
        logic [7:0] base;
        base = 8'h00;
        rdata_next = mpio_pkg::READ_UNMAPPED;
        if (reg_rd) begin
            if (reg_addr == mpio_pkg::ADDR_CTRL) begin
                rdata_next = ctrl_reg;
            end else if (reg_addr == mpio_pkg::ADDR_OUT_VALUE) begin
                rdata_next = {MODULE_TYPE, 24'h0}; // see RQ6
            end else if (reg_addr == mpio_pkg::ADDR_PULSE_VALUES) begin
                // both per-pulse values share one word, clear of the channel windows
                rdata_next = {mpio_pkg::OUT_VOLUME_VALUE[15:0], mpio_pkg::OUT_ENERGY_VALUE[15:0]}; // see RQ6
            end else if (reg_addr == mpio_pkg::ADDR_STATUS) begin
                rdata_next = {30'h0, out_busy};
            end else begin
                for (int i = 0; i < NUM_IN; i++) begin
                    base = 8'(mpio_pkg::ADDR_CH_BASE + 8'(i) * mpio_pkg::CH_STRIDE);
                    if (reg_addr == base + {4'h0, mpio_pkg::CH_CFG}) begin
                        rdata_next = cfg_reg[i]; // see RQ11
                    end else if (reg_addr == base + {4'h0, mpio_pkg::CH_TOTAL}) begin
                        rdata_next = total_reg[i]; // see RQ7
                    end else if (reg_addr == base + {4'h0, mpio_pkg::CH_SERIAL}) begin
                        rdata_next = serial_reg[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= mpio_pkg::CTRL_RESET;
            rdata_reg <= 32'h0000_0000;
            for (int i = 0; i < NUM_IN; i++) begin
                cfg_reg[i] <= 32'h0000_0000;
                serial_reg[i] <= 32'h0000_0000;
                total_reg[i] <= 32'h0000_0000;
            end
        end else begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rdata_next;
            for (int i = 0; i < NUM_IN; i++) begin
                cfg_reg[i] <= cfg_next[i];
                serial_reg[i] <= serial_next[i];
                total_reg[i] <= total_next[i];
            end
        end
    end
    assign reg_rdata = rdata_reg;

    // ****************************************
    // pulse outputs
    // ****************************************
    logic out_en;
    assign out_en = ctrl_reg[mpio_pkg::CTRL_OUT_EN_BIT];

    mpio_pulse_out #(.CLOSED_CYCLES(OUT_CLOSED_CYCLES), .OPEN_CYCLES(OUT_OPEN_CYCLES)) u_energy (
        .core_clk(core_clk),
        .nrst(nrst),
        .enable(out_en),
        .step(energy_step), // see RQ3
        .switch_closed(energy_switch),
        .busy(out_busy[0])
    );

    mpio_pulse_out #(.CLOSED_CYCLES(OUT_CLOSED_CYCLES), .OPEN_CYCLES(OUT_OPEN_CYCLES)) u_volume (
        .core_clk(core_clk),
        .nrst(nrst),
        .enable(out_en),
        .step(volume_step), // see RQ4
        .switch_closed(volume_switch),
        .busy(out_busy[1])
    );

    // ****************************************
    // pulse inputs
    // ****************************************
    for (genvar g = 0; g < NUM_IN; g++) begin : g_in
        mpio_pulse_in #(.QUAL_CYCLES(IN_QUAL_CYCLES)) u_in (
            .core_clk(core_clk),
            .nrst(nrst),
            .pin_n(pulse_in_n[g]),
            .count(count_ev[g])
        );
    end
endmodule : mpio_top

// one switch output: 125 ms closed, 125 ms open, steps queued
module mpio_pulse_out #(
    parameter int CLOSED_CYCLES = 12_500_000,
    parameter int OPEN_CYCLES = 12_500_000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // control
    input wire logic enable,
    input wire logic step,
    // status
    output logic switch_closed,
    output logic busy
);
    typedef enum logic [1:0] {PO_IDLE, PO_CLOSED, PO_OPEN} mpio_po_state_type;
    mpio_po_state_type state_reg, state_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [15:0] pend_reg, pend_next;
    logic sw_reg, sw_next;

    // next state of the pulse generator
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        pend_next = pend_reg;
        sw_next = 1'b0;
        if (step && enable && pend_reg != 16'hffff) begin
            pend_next = pend_reg + 16'h0001;
        end
        case (state_reg)
            PO_IDLE: begin
                if (pend_next != 16'h0000 && enable) begin
                    pend_next = pend_next - 16'h0001;
                    state_next = PO_CLOSED;
                    cnt_next = 32'(CLOSED_CYCLES - 1);
                    sw_next = 1'b1;
                end
            end
            PO_CLOSED: begin
                sw_next = 1'b1;
                if (cnt_reg == 32'h0) begin
                    state_next = PO_OPEN; // see RQ1
                    cnt_next = 32'(OPEN_CYCLES - 1);
                    sw_next = 1'b0;
                end else begin
                    cnt_next = cnt_reg - 32'h1;
                end
            end
            PO_OPEN: begin
                if (cnt_reg == 32'h0) begin
                    state_next = PO_IDLE; // see RQ2
                end else begin
                    cnt_next = cnt_reg - 32'h1;
                end
            end
            default: state_next = PO_IDLE;
        endcase
        if (!enable) begin
            pend_next = 16'h0000; // see RQ5
            if (state_reg == PO_CLOSED || state_next == PO_CLOSED) begin
                state_next = PO_OPEN;
                cnt_next = 32'(OPEN_CYCLES - 1);
            end
            sw_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= PO_IDLE;
            cnt_reg <= 32'h0;
            pend_reg <= 16'h0000;
            sw_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pend_reg <= pend_next;
            sw_reg <= sw_next;
        end
    end
    assign switch_closed = sw_reg;
    assign busy = (state_reg != PO_IDLE);
endmodule : mpio_pulse_out

// one input: two-flop sync, debounce, pulse on release
module mpio_pulse_in #(
    parameter int QUAL_CYCLES = 5_000_000
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // pin and event
    input wire logic pin_n,
    output logic count
);
    logic s1_reg, s2_reg, lvl_reg, lvl_next, cnt_ev_reg, cnt_ev_next;
    logic [31:0] q_reg, q_next;

    // level changes only after standing QUAL_CYCLES; count on release
    always_comb begin
        lvl_next = lvl_reg;
        q_next = q_reg;
        cnt_ev_next = 1'b0;
        if ((~s2_reg) == lvl_reg) begin
            q_next = 32'h0; // see RQ14
        end else if (q_reg == 32'(QUAL_CYCLES - 1)) begin
            q_next = 32'h0;
            lvl_next = ~s2_reg; // see RQ13
            cnt_ev_next = lvl_reg; // see RQ14
        end else begin
            q_next = q_reg + 32'h1; // see RQ12
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            lvl_reg <= 1'b0;
            q_reg <= 32'h0;
            cnt_ev_reg <= 1'b0;
        end else begin
            s1_reg <= pin_n;
            s2_reg <= s1_reg;
            lvl_reg <= lvl_next;
            q_reg <= q_next;
            cnt_ev_reg <= cnt_ev_next;
        end
    end
    assign count = cnt_ev_reg;
endmodule : mpio_pulse_in

// ### rtl/mpio_pkg.sv
// package: constants for the meter pulse input/output block
package mpio_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int OUT_CLOSED_MS = 125;
    localparam int OUT_OPEN_MS = 125;
    localparam int IN_MIN_MS = 100;
    localparam int OUT_CLOSED_CYC = (OUT_CLOSED_MS * (CLK_HZ / 1000));
    localparam int OUT_OPEN_CYC = (OUT_OPEN_MS * (CLK_HZ / 1000));
    // debounce qualifies at half the least pulse length
    localparam int IN_QUAL_CYC = (IN_MIN_MS * (CLK_HZ / 1000)) / 2;
    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OUT_VALUE = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_PULSE_VALUES = 8'h0c; // [15:0] energy, [31:16] volume
    localparam logic [7:0] ADDR_CH_BASE = 8'h10;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [3:0] CH_CFG = 4'h0;
    localparam logic [3:0] CH_START = 4'h4;
    localparam logic [3:0] CH_TOTAL = 4'h8;
    localparam logic [3:0] CH_SERIAL = 4'hc;
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int CTRL_OUT_EN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam int CFG_WEIGHT_LSB = 0;
    localparam int CFG_UNIT_LSB = 4;
    localparam int CFG_MFR_LSB = 16;
    localparam logic [2:0] WEIGHT_1 = 3'h0;
    localparam logic [2:0] WEIGHT_2P5 = 3'h1;
    localparam logic [2:0] WEIGHT_10 = 3'h2;
    localparam logic [2:0] WEIGHT_25 = 3'h3;
    localparam logic [2:0] WEIGHT_100 = 3'h4;
    localparam logic [2:0] WEIGHT_250 = 3'h5;
    localparam logic [2:0] WEIGHT_1000 = 3'h6;
    localparam logic [1:0] UNIT_NONE = 2'h0;
    localparam logic [1:0] UNIT_LITRE = 2'h1;
    localparam logic [1:0] UNIT_KWH = 2'h2;
    // per-pulse values in tenths so that 2.5 is whole
    localparam logic [31:0] OUT_ENERGY_VALUE = 32'h0000_000a; // 1 kWh, tenths
    localparam logic [31:0] OUT_VOLUME_VALUE = 32'h0000_0064; // 10 l, tenths
    localparam logic [7:0] MODULE_TYPE_DEFAULT = 8'h0a; // value arbitrary
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
endpackage : mpio_pkg

// ### bench/mpio_assertions.sv
// checker: port assertions for the meter pulse block
`timescale 1ns/10ps
module mpio_assertions #(
    parameter int OUT_CLOSED_CYCLES = 20,
    parameter int OUT_OPEN_CYCLES = 20
) (
    // watched ports
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic energy_switch,
    input wire logic volume_switch
);
    int e_hi, v_hi, e_lo, v_lo;
    logic en_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // run lengths of closed and open contact, mirrored output enable
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            e_hi <= 0;
            v_hi <= 0;
            e_lo <= OUT_OPEN_CYCLES;
            v_lo <= OUT_OPEN_CYCLES;
            en_q <= 1'b1;
        end else begin
            e_hi <= energy_switch ? e_hi + 1 : 0;
            v_hi <= volume_switch ? v_hi + 1 : 0;
            e_lo <= energy_switch ? 0 : (e_lo < 1000 ? e_lo + 1 : e_lo);
            v_lo <= volume_switch ? 0 : (v_lo < 1000 ? v_lo + 1 : v_lo);
            if (reg_wr && reg_addr == mpio_pkg::ADDR_CTRL) en_q <= reg_wdata[0];
        end
    end
    // ****
    // switch timing and enable
    // ****
    // a pulse cut short by disabling the outputs is not a timed pulse
    property p_e_closed; $fell(energy_switch) && en_q |-> e_hi == OUT_CLOSED_CYCLES; endproperty
    a_e_closed: assert property (p_e_closed) else $error("energy pulse length wrong");
    property p_v_closed; $fell(volume_switch) && en_q |-> v_hi == OUT_CLOSED_CYCLES; endproperty
    a_v_closed: assert property (p_v_closed) else $error("volume pulse length wrong");
    property p_e_open; $rose(energy_switch) |-> e_lo >= OUT_OPEN_CYCLES; endproperty
    a_e_open: assert property (p_e_open) else $error("energy open gap short");
    property p_v_open; $rose(volume_switch) |-> v_lo >= OUT_OPEN_CYCLES; endproperty
    a_v_open: assert property (p_v_open) else $error("volume open gap short");
    property p_en_gate; $rose(energy_switch) || $rose(volume_switch) |-> $past(en_q); endproperty
    a_en_gate: assert property (p_en_gate) else $error("switch closed while disabled");
    property p_disable;
        reg_wr && reg_addr == mpio_pkg::ADDR_CTRL && !reg_wdata[0] |-> ##2 (!energy_switch && !volume_switch)[*4];
    endproperty
    a_disable: assert property (p_disable) else $error("switch not opened on disable");
    // ****
    // register read port
    // ****
    property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_rd_ctrl; reg_rd && reg_addr == mpio_pkg::ADDR_CTRL |=> reg_rdata[0] == $past(en_q); endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("enable readback wrong");
endmodule : mpio_assertions

bind mpio_top mpio_assertions #(.OUT_CLOSED_CYCLES(OUT_CLOSED_CYCLES), .OUT_OPEN_CYCLES(OUT_OPEN_CYCLES)) u_chk (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .energy_switch(energy_switch), .volume_switch(volume_switch));

// ### bench/mpio_meter_model.sv
// partner: external meters driving the three pulse inputs
`timescale 1ns/10ps
module mpio_meter_model (
    // clock
    input wire logic core_clk,
    // contact lines, low while closed
    output logic [2:0] pulse_in_n
);
    // lines are pulled up while contacts are open
    initial pulse_in_n = 3'h7;
    // close a contact or short its wires, then open it again
    task automatic pulse(input int ch, input int on_cyc, input int off_cyc);
        @(posedge core_clk);
        pulse_in_n[ch] <= 1'b0;
        repeat (on_cyc) @(posedge core_clk);
        pulse_in_n[ch] <= 1'b1;
        repeat (off_cyc) @(posedge core_clk);
    endtask : pulse
endmodule : mpio_meter_model

// ### bench/tb_top.sv
// testbench: register tasks and scenarios for the meter pulse block
`timescale 1ns/10ps
module tb_top;
    // ****
    // clock, reset and design inputs
    // ****
    localparam int CLOSED = 20;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic energy_step = 1'b0;
    logic volume_step = 1'b0;
    logic energy_switch, volume_switch;
    logic [2:0] pulse_in_n;
    int err_count = 0;
    int n_checks = 0;
    int e_cnt = 0;
    int v_cnt = 0;
    int e_len = 0;
    time t_rise = 0;
    int wt[7] = '{10, 25, 100, 250, 1000, 2500, 10000};
    always #5 core_clk = ~core_clk;
    // design and external meters
    mpio_top #(.OUT_CLOSED_CYCLES(CLOSED), .OUT_OPEN_CYCLES(20), .IN_QUAL_CYCLES(8)) uut (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .energy_step(energy_step), .volume_step(volume_step),
        .energy_switch(energy_switch), .volume_switch(volume_switch), .pulse_in_n(pulse_in_n));
    mpio_meter_model meter (.core_clk(core_clk), .pulse_in_n(pulse_in_n));
    // count closures and time the energy contact
    always @(posedge energy_switch) begin e_cnt++; t_rise = $time; end
    always @(negedge energy_switch) e_len = int'(($time - t_rise) / 10);
    always @(posedge volume_switch) v_cnt++;
    // ****
    // tasks
    // ****
    task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
        n_checks++;
        if (got !== want) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask : check
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_check(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] want);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(reg_rdata & mask, want, "register read");
    endtask : reg_check
    task automatic step(input logic e, input logic v);
        @(posedge core_clk);
        energy_step <= e;
        volume_step <= v;
        @(posedge core_clk);
        energy_step <= 1'b0;
        volume_step <= 1'b0;
    endtask : step
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize
    // ****
    // scenarios
    // ****
    initial begin
        logic [7:0] ba;
        logic [31:0] want[3];
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        reg_check(mpio_pkg::ADDR_CTRL, 32'h1, 32'h1);
        reg_check(mpio_pkg::ADDR_OUT_VALUE, 32'hff00_0000, {mpio_pkg::MODULE_TYPE_DEFAULT, 24'h0});
        reg_check(mpio_pkg::ADDR_PULSE_VALUES, 32'hffff_ffff, {16'd100, 16'd10});
        reg_check(8'hfc, 32'hffff_ffff, 32'h0);
        $display("test registers done");
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        reg_check(mpio_pkg::ADDR_STATUS, 32'h3, 32'h3);
        repeat (140) @(posedge core_clk);
        check(32'(e_cnt), 32'd1, "energy pulses");
        check(32'(v_cnt), 32'd3, "volume pulses");
        check(32'(e_len), 32'(CLOSED), "closed length");
        $display("test outputs done");
        step(1'b1, 1'b0);
        repeat (4) @(posedge core_clk);
        reg_write(mpio_pkg::ADDR_CTRL, 32'h0);
        step(1'b1, 1'b1);
        repeat (60) @(posedge core_clk);
        check({energy_switch, volume_switch, 30'(e_cnt)}, 32'd2, "disabled outputs");
        reg_check(mpio_pkg::ADDR_CTRL, 32'h1, 32'h0);
        reg_write(mpio_pkg::ADDR_CTRL, 32'h1);
        step(1'b1, 1'b0);
        repeat (50) @(posedge core_clk);
        check(32'(e_cnt), 32'd3, "queue cleared");
        $display("test disable done");
        for (int i = 0; i < 7; i++) begin
            ba = 8'(16 + 16 * (i % 3));
            want[i % 3] = 32'(1000 * i + 7 + 2 * wt[i]);
            reg_write(ba, {16'(16'h4d00 + i), 10'h0, 2'(i % 3), 1'b0, 3'(i)});
            reg_write(ba + 8'(mpio_pkg::CH_START), 32'(1000 * i + 7));
            reg_write(ba + 8'(mpio_pkg::CH_SERIAL), 32'h5e00_0000 + 32'(i));
            meter.pulse(i % 3, 20, 20);
            meter.pulse(i % 3, 4, 20);
            meter.pulse(i % 3, 20, 20);
            reg_check(ba + 8'(mpio_pkg::CH_TOTAL), 32'hffff_ffff, want[i % 3]);
            reg_check(ba, 32'hffff_0037, {16'(16'h4d00 + i), 10'h0, 2'(i % 3), 1'b0, 3'(i)});
            reg_check(ba + 8'(mpio_pkg::CH_SERIAL), 32'hffff_ffff, 32'h5e00_0000 + 32'(i));
        end
        for (int c = 0; c < 3; c++) begin
            reg_check(8'(16 + 16 * c) + 8'(mpio_pkg::CH_TOTAL), 32'hffff_ffff, want[c]);
        end
        $display("test inputs done");
        summarize();
    end
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end
endmodule : tb_top
